// ==== verilog/sar_adc_ctrl.sv ====
// Control logic of a 10-bit successive-approximation converter behind an AHB-Lite slave.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
// Operation
// - Produce 10-bit result, store in result pair.
// - Channel select routes one input to hold.
// - Five pins, reference, temperature, fixed reference.
// - Channel codes map; other codes connect nothing.
// - Enable low disconnects every multiplexer input.
// - Reference select picks pin, supply or fixed.
// - Clock select picks divided clock or RC.
// - Clock select encoding, x11 means RC.
// - One bit per period, 11.5 periods total.
// - Divided clock tracks system clock frequency.
// - Sleep conversion runs only with RC clock.
// - Completion clears busy, sets flag, loads results.
// - Done flag set regardless of irq enable.
// - Only software clears the done flag.
// - Interrupt when flag and enable both set.
// - Enabled completion in sleep wakes device.
// - Branch to handler if global, peripheral enabled.
// - Format bit selects left or right justify.
// - Unused six bits load as zero.
module sar_adc_ctrl
  import sar_adc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic cmp_in,
  input wire logic rc_tick,
  input wire logic sleep_mode,
  output logic [7:0] mux_select,
  output logic [1:0] ref_select,
  output logic sample_hold,
  output logic [9:0] trial_code,
  output logic busy,
  output logic irq_request,
  output logic wake_request,
  output logic isr_branch
);
  // Bus pipeline registers.
  logic [7:0] addr_ff;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic hresp_ff;
  // Control state written by software.
  logic converter_enable_ff;
  logic [4:0] channel_select_ff;
  conv_cfg_type cfg_ff;
  logic go_ff;
  logic conversion_done_flag_ff;
  logic conversion_irq_enable_ff;
  logic global_irq_enable_ff;
  logic peripheral_irq_enable_ff;
  // Results and sequencer.
  logic [7:0] result_high_reg_ff;
  logic [7:0] result_low_reg_ff;
  state_type state_ff;
  logic [4:0] half_ff;
  logic [3:0] bit_ff;
  logic [9:0] trial_code_ff;
  logic [5:0] div_cnt_ff;
  logic samp_ff;
  logic [7:0] mux_ff;
  logic [1:0] ref_ff;
  logic irq_ff;
  logic wake_ff;
  logic isr_ff;

  // Register offset match on the word address bits.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction

  // One-hot multiplexer select; all zero when disabled or on a reserved code.
  function automatic logic [7:0] chan_decode(input logic [4:0] chan, input logic en);
    logic [7:0] sel;
    sel = 8'h00;
    if (en) begin
      if (chan <= CHAN_PIN_LAST) begin
        sel[chan[2:0]] = 1'b1;
      end else if (chan == CHAN_POS_REF) begin
        sel[5] = 1'b1;
      end else if (chan == CHAN_TEMP) begin
        sel[6] = 1'b1;
      end else if (chan == CHAN_FIXED_REF) begin
        sel[7] = 1'b1;
      end
    end
    return sel;
  endfunction

  // Last divider count of a half bit period for each divided clock code.
  function automatic logic [5:0] half_limit(input logic [2:0] sel);
    logic [5:0] lim;
    unique case (sel)
      CLK_DIV2: lim = 6'h00;
      CLK_DIV4: lim = 6'h01;
      CLK_DIV8: lim = 6'h03;
      CLK_DIV16: lim = 6'h07;
      CLK_DIV32: lim = 6'h0f;
      CLK_DIV64: lim = 6'h1f;
      default: lim = 6'h00;
    endcase
    return lim;
  endfunction

  // Places a code into {high, low}, zeroing the six unused bits.
  function automatic logic [15:0] justify_code(input logic [9:0] code, input logic right);
    return right ? {6'h00, code} : {code, 6'h00};
  endfunction

  // Aborted code: undecided bits copy the last decided bit.
  function automatic logic [9:0] partial_code(input logic [9:0] code, input logic [3:0] idx);
    logic fill;
    logic [9:0] res;
    fill = (idx < MSB_INDEX) ? code[idx + 4'h1] : 1'b0;
    res = code;
    for (int i = 0; i < 10; i++) begin
      if (i <= int'(idx)) begin
        res[i] = fill;
      end
    end
    return res;
  endfunction

  logic accept;
  logic [7:0] wdata;
  logic rc_sel;
  logic half_tick;
  logic decide;
  logic done;
  logic sw_abort;
  logic hw_abort;
  logic [9:0] decided;
  assign accept = hsel & hready & htrans[1];
  assign wdata = hwdata[7:0];
  assign rc_sel = cfg_ff.clk_sel[1:0] == CLK_RC_LOW;
  // The RC tick arrives per half period; otherwise the divider follows hclk directly.
  assign half_tick = rc_sel ? rc_tick : (div_cnt_ff == half_limit(cfg_ff.clk_sel));
  assign decide = half_tick && (state_ff == ST_CONVERT) && !half_ff[0];
  assign done = decide && (bit_ff == 4'h0);
  assign sw_abort = wr_pend_ff && reg_hit(addr_ff, OFF_CTRL0) && !wdata[CTRL0_GO_BIT]
    && (state_ff != ST_IDLE);
  // A sleep without the RC clock, or a disable, stops the conversion with no result.
  assign hw_abort = (state_ff != ST_IDLE) && ((sleep_mode && !rc_sel) || !converter_enable_ff);
  always_comb begin
    decided = trial_code_ff;
    decided[bit_ff] = cmp_in;
  end

  // Address phase capture; reads take one wait state so data come from a flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 8'h00;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
    end else begin
      addr_ff <= accept ? haddr[7:0] : addr_ff;
      wr_pend_ff <= accept & hwrite;
      rd_pend_ff <= accept & ~hwrite;
    end
  end

  // Read data and ready; unmapped reads return zero, every answer is OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
      hreadyout_ff <= !(accept && !hwrite);
      if (rd_pend_ff) begin
        hrdata_ff <= 32'h0000_0000;
        if (reg_hit(addr_ff, OFF_CTRL0)) begin
          hrdata_ff[7:0] <= {1'b0, channel_select_ff, go_ff, converter_enable_ff};
        end else if (reg_hit(addr_ff, OFF_CTRL1)) begin
          hrdata_ff[7:0] <= {cfg_ff.justify, cfg_ff.clk_sel, 2'b00, cfg_ff.ref_sel};
        end else if (reg_hit(addr_ff, OFF_RES_HIGH)) begin
          hrdata_ff[7:0] <= result_high_reg_ff;
        end else if (reg_hit(addr_ff, OFF_RES_LOW)) begin
          hrdata_ff[7:0] <= result_low_reg_ff;
        end else if (reg_hit(addr_ff, OFF_FLAG)) begin
          hrdata_ff[FLAG_DONE_BIT] <= conversion_done_flag_ff;
        end else if (reg_hit(addr_ff, OFF_ENABLE)) begin
          hrdata_ff[ENABLE_IRQ_BIT] <= conversion_irq_enable_ff;
        end else if (reg_hit(addr_ff, OFF_IRQ_CTRL)) begin
          hrdata_ff[GLOBAL_IRQ_BIT] <= global_irq_enable_ff;
          hrdata_ff[PERIPH_IRQ_BIT] <= peripheral_irq_enable_ff;
        end
      end
    end
  end

  // Plain control fields written in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_enable_ff <= CTRL_RESET[CTRL0_EN_BIT];
      channel_select_ff <= CTRL_RESET[6:2];
      cfg_ff <= '0;
      conversion_irq_enable_ff <= 1'b0;
      global_irq_enable_ff <= 1'b0;
      peripheral_irq_enable_ff <= 1'b0;
    end else if (wr_pend_ff) begin
      if (reg_hit(addr_ff, OFF_CTRL0)) begin
        converter_enable_ff <= wdata[CTRL0_EN_BIT];
        channel_select_ff <= wdata[CTRL0_CHAN_LSB +: 5];
      end
      if (reg_hit(addr_ff, OFF_CTRL1)) begin
        cfg_ff <= {wdata[CTRL1_JUST_BIT], wdata[CTRL1_CLK_LSB +: 3], wdata[CTRL1_REF_LSB +: 2]};
      end
      if (reg_hit(addr_ff, OFF_ENABLE)) begin
        conversion_irq_enable_ff <= wdata[ENABLE_IRQ_BIT];
      end
      if (reg_hit(addr_ff, OFF_IRQ_CTRL)) begin
        global_irq_enable_ff <= wdata[GLOBAL_IRQ_BIT];
        peripheral_irq_enable_ff <= wdata[PERIPH_IRQ_BIT];
      end
    end
  end

  // Start/busy bit: a start needs the converter already enabled, so the
  // same write that turns it on cannot also start it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_ff <= 1'b0;
    end else if (done || hw_abort) begin
      go_ff <= 1'b0;
    end else if (wr_pend_ff && reg_hit(addr_ff, OFF_CTRL0)) begin
      go_ff <= wdata[CTRL0_GO_BIT] & converter_enable_ff;
    end
  end

  // Done flag: hardware only sets it; a software write in the same cycle loses.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_done_flag_ff <= 1'b0;
    end else if (done) begin
      conversion_done_flag_ff <= 1'b1;
    end else if (wr_pend_ff && reg_hit(addr_ff, OFF_FLAG)) begin
      conversion_done_flag_ff <= wdata[FLAG_DONE_BIT];
    end
  end

  // Half-period divider, restarted while idle so every divided-clock conversion has whole periods.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_ff <= 6'h00;
    end else if (state_ff == ST_IDLE || half_tick) begin
      div_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end
  end

  // Sequencer: 1.5 periods of sampling, then ten decisions, MSB first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      half_ff <= 5'h00;
      bit_ff <= MSB_INDEX;
      trial_code_ff <= 10'h000;
      samp_ff <= 1'b0;
    end else if (hw_abort || sw_abort) begin
      state_ff <= ST_IDLE;
      samp_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          half_ff <= 5'h00;
          bit_ff <= MSB_INDEX;
          if (go_ff && converter_enable_ff) begin
            state_ff <= ST_SAMPLE;
            trial_code_ff <= 10'h000;
            samp_ff <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (half_tick) begin
            half_ff <= half_ff + 5'h01;
            if (half_ff == SAMPLE_LAST_HALF) begin
              state_ff <= ST_CONVERT;
              samp_ff <= 1'b0;
              trial_code_ff <= MSB_TRIAL;
            end
          end
        end
        ST_CONVERT: begin
          if (half_tick) begin
            half_ff <= half_ff + 5'h01;
          end
          if (decide) begin
            trial_code_ff <= decided;
            if (bit_ff == 4'h0) begin
              state_ff <= ST_IDLE;
            end else begin
              trial_code_ff[bit_ff - 4'h1] <= 1'b1;
              bit_ff <= bit_ff - 4'h1;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Result pair: loaded at completion, or with the partial code on a software abort.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_high_reg_ff <= 8'h00;
      result_low_reg_ff <= 8'h00;
    end else if (done) begin
      {result_high_reg_ff, result_low_reg_ff} <= justify_code(decided, cfg_ff.justify);
    end else if (sw_abort) begin
      {result_high_reg_ff, result_low_reg_ff} <=
        justify_code(partial_code(trial_code_ff, bit_ff), cfg_ff.justify);
    end
  end

  // Analog-side selects, registered so the pins never glitch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mux_ff <= 8'h00;
      ref_ff <= 2'h0;
    end else begin
      mux_ff <= chan_decode(channel_select_ff, converter_enable_ff);
      ref_ff <= cfg_ff.ref_sel;
    end
  end

  // Interrupt request, wake from sleep and handler branch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
      isr_ff <= 1'b0;
    end else begin
      irq_ff <= conversion_done_flag_ff & conversion_irq_enable_ff;
      wake_ff <= conversion_done_flag_ff & conversion_irq_enable_ff & sleep_mode;
      isr_ff <= conversion_done_flag_ff & conversion_irq_enable_ff
        & global_irq_enable_ff & peripheral_irq_enable_ff;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;
  assign mux_select = mux_ff;
  assign ref_select = ref_ff;
  assign sample_hold = samp_ff;
  assign trial_code = trial_code_ff;
  assign busy = go_ff;
  assign irq_request = irq_ff;
  assign wake_request = wake_ff;
  assign isr_branch = isr_ff;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_MUX_OFF: assert property (!converter_enable_ff |=> mux_ff == 8'h00)
    else $error("multiplexer connected while disabled");
  AST_MSB_FIRST: assert property (state_ff == ST_SAMPLE && half_tick && half_ff == 5'h02
    && !hw_abort && !sw_abort
    |=> trial_code_ff == 10'h200 && state_ff == ST_CONVERT)
    else $error("first trial is not the top bit");
  AST_SEQ_LEN: assert property (done |-> half_ff == 5'h16 && bit_ff == 4'h0)
    else $error("conversion did not last 23 half periods");
  AST_DONE: assert property (done && !hw_abort |=> conversion_done_flag_ff && !go_ff)
    else $error("completion did not set flag and clear busy");
  AST_FLAG_HOLD: assert property (conversion_done_flag_ff
    && !(wr_pend_ff && reg_hit(addr_ff, OFF_FLAG)) |=> conversion_done_flag_ff)
    else $error("done flag cleared without software");
  AST_RIGHT: assert property (done && cfg_ff.justify |=> result_high_reg_ff[7:2] == 6'h00)
    else $error("right justified high bits not zero");
  AST_LEFT: assert property (done && !cfg_ff.justify |=> result_low_reg_ff[5:0] == 6'h00)
    else $error("left justified low bits not zero");
  AST_IRQ: assert property (conversion_done_flag_ff && conversion_irq_enable_ff
    |=> irq_ff ##0 (wake_ff == $past(sleep_mode)))
    else $error("interrupt or wake missing");
  AST_SLEEP: assert property (sleep_mode && !rc_sel && state_ff != ST_IDLE
    |=> state_ff == ST_IDLE && !go_ff)
    else $error("conversion ran in sleep without RC clock");
  AST_DIV2: assert property (state_ff != ST_IDLE && cfg_ff.clk_sel == 3'h0 |-> half_tick)
    else $error("divide-by-2 half period is not one cycle");
  COV_DONE: cover property (done);
  COV_ABORT: cover property (sw_abort);
  COV_WAKE: cover property (wake_ff && isr_ff);
endmodule // sar_adc_ctrl

// ==== verilog/sar_adc_pkg.sv ====
// Package: register map, field positions, codes and sequence constants for the converter control.
package sar_adc_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_RES_HIGH = 8'h08;
  localparam logic [7:0] OFF_RES_LOW = 8'h0c;
  localparam logic [7:0] OFF_FLAG = 8'h10;
  localparam logic [7:0] OFF_ENABLE = 8'h14;
  localparam logic [7:0] OFF_IRQ_CTRL = 8'h18;
  // Field positions.
  localparam int CTRL0_EN_BIT = 0;
  localparam int CTRL0_GO_BIT = 1;
  localparam int CTRL0_CHAN_LSB = 2;
  localparam int CTRL1_REF_LSB = 0;
  localparam int CTRL1_CLK_LSB = 4;
  localparam int CTRL1_JUST_BIT = 7;
  localparam int FLAG_DONE_BIT = 0;
  localparam int ENABLE_IRQ_BIT = 0;
  localparam int PERIPH_IRQ_BIT = 6;
  localparam int GLOBAL_IRQ_BIT = 7;
  // Reset value of every control register.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Channel select codes.
  localparam logic [4:0] CHAN_PIN_LAST = 5'h04;
  localparam logic [4:0] CHAN_POS_REF = 5'h1a;
  localparam logic [4:0] CHAN_TEMP = 5'h1d;
  localparam logic [4:0] CHAN_FIXED_REF = 5'h1f;
  // Clock select codes; both x11 codes pick the RC oscillator.
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [1:0] CLK_RC_LOW = 2'h3;
  // Sequence counted in half bit periods: 3 for sampling, 2 per bit, 23 in all.
  localparam logic [4:0] SAMPLE_LAST_HALF = 5'h02;
  localparam logic [4:0] LAST_HALF = 5'h16;
  localparam logic [3:0] MSB_INDEX = 4'h9;
  localparam logic [9:0] MSB_TRIAL = 10'h200;
  // Conversion settings that travel together.
  typedef struct packed {
    logic justify;
    logic [2:0] clk_sel;
    logic [1:0] ref_sel;
  } conv_cfg_type;
  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } state_type;
endpackage

// ==== test/sar_analog_model.sv ====
// Analog side model: comparator against a held input level and a free-running RC strobe.
`timescale 1ns/100ps
module sar_analog_model #(
  parameter int RC_HALF = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [9:0] level,
  input wire logic [9:0] trial_code,
  output logic cmp_in,
  output logic rc_tick
);
  // The comparator settles well within one cycle, so it answers at once.
  assign cmp_in = (level >= trial_code);
  // Half-period counter; the RC oscillator runs free, so ticks keep coming between conversions.
  int cnt_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 0;
    end else begin
      cnt_ff <= (cnt_ff == RC_HALF - 1) ? 0 : cnt_ff + 1;
    end
  end
  // One strobe per half RC period, as the sequencer expects.
  assign rc_tick = (cnt_ff == RC_HALF - 1);
endmodule // sar_analog_model

// ==== test/tb_top.sv ====
// Self-checking bench for the converter control, driven over AHB-Lite.
`timescale 1ns/100ps
module tb_top;
  import sar_adc_pkg::*;
  localparam int RC_HALF = 6;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cmp_in, rc_tick, sleep_mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, ref_select;
  logic [2:0] hsize;
  logic [7:0] mux_select;
  logic [9:0] trial_code, level;
  logic sample_hold, busy, irq_request, wake_request, isr_branch;
  int miscompares, tests_run, cycles;
  // Channel codes with the one-hot routing each should give; the last two connect nothing.
  logic [4:0] chan_codes [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1a, 5'h1d, 5'h1f,
    5'h05, 5'h1e};
  logic [7:0] hot [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h00, 8'h00};
  // Clock selects with their half bit period in cycles; x11 uses the RC strobe.
  logic [2:0] csel [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int hper [8] = '{1, 2, 4, 8, 16, 32, RC_HALF, RC_HALF};
  logic [9:0] vals [8] = '{10'h2a5, 10'h3ff, 10'h000, 10'h155, 10'h0aa, 10'h201, 10'h1fe, 10'h333};

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  sar_adc_ctrl sar_adc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmp_in(cmp_in), .rc_tick(rc_tick),
    .sleep_mode(sleep_mode), .mux_select(mux_select), .ref_select(ref_select),
    .sample_hold(sample_hold), .trial_code(trial_code), .busy(busy),
    .irq_request(irq_request), .wake_request(wake_request), .isr_branch(isr_branch));

  sar_analog_model #(.RC_HALF(RC_HALF)) sar_analog_model_i (.hclk(hclk), .hresetn(hresetn),
    .level(level), .trial_code(trial_code), .cmp_in(cmp_in), .rc_tick(rc_tick));

  // Free-running 125 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang in any wait ends the run well after the tests should be done.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  // Compares a seen value with an expected one, case-exact.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Single write: address phase held until ready, then data held until ready.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // Single read: data taken at the edge where ready is seen high in the data phase.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  // Reads a register and compares it.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  // One full conversion; timing, first trial, sampling phase and both result words are checked.
  task automatic convert(input logic [2:0] cs, input logic just, input logic [9:0] v,
                         input int h);
    int n;
    logic sh, got;
    logic [9:0] first;
    n = 0;
    sh = 1'b0;
    got = 1'b0;
    first = 10'h0;
    level <= v;
    wr(OFF_CTRL1, {just, cs, 4'h0});
    wr(OFF_FLAG, 8'h00);
    wr(OFF_CTRL0, 8'h01);
    wr(OFF_CTRL0, 8'h03);
    @(posedge hclk);
    while (busy === 1'b1 && n < 3000) begin
      // The first trial is the one shown as sampling ends.
      if (sh && !got && sample_hold === 1'b0) begin
        first = trial_code;
        got = 1'b1;
      end
      sh = sh | (sample_hold === 1'b1);
      @(posedge hclk);
      n++;
    end
    check({31'h0, (n > 22 * h) && (n <= 23 * h + 3)}, 32'h1);
    check({22'h0, first}, 32'h200);
    check({31'h0, sh}, 32'h1);
    rd_chk(OFF_FLAG, 32'h1);
    rd_chk(OFF_RES_HIGH, just ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
    rd_chk(OFF_RES_LOW, just ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0});
  endtask

  // Main sequence.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    level = 10'h0;
    sleep_mode = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and an unmapped place.
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'(4 * i), {24'h0, CTRL_RESET});
    end
    rd_chk(8'h1c, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // Go together with the enable is not taken; bit 7 and bits 3..2 read as zero.
    wr(OFF_CTRL0, 8'hff);
    rd_chk(OFF_CTRL0, 32'h7d);
    wr(OFF_CTRL1, 8'hff);
    rd_chk(OFF_CTRL1, 32'hf3);
    // With the converter off nothing is routed, whatever the code.
    wr(OFF_CTRL0, 8'h7c);
    repeat (2) @(posedge hclk);
    check({24'h0, mux_select}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(OFF_CTRL0, {1'b0, chan_codes[i], 2'b01});
      repeat (2) @(posedge hclk);
      check({24'h0, mux_select}, {24'h0, hot[i]});
    end
    for (int r = 0; r < 3; r++) begin
      wr(OFF_CTRL1, 8'(r));
      repeat (2) @(posedge hclk);
      check({30'h0, ref_select}, 32'(r));
    end
    // Every clock select, alternating the justification.
    for (int i = 0; i < 8; i++) begin
      convert(csel[i], i[0], vals[i], hper[i]);
    end
    check({31'h0, irq_request}, 32'h0);
    // Interrupt enable, then global and peripheral enables.
    wr(OFF_ENABLE, 8'h01);
    wr(OFF_IRQ_CTRL, 8'hc0);
    repeat (2) @(posedge hclk);
    check({29'h0, irq_request, wake_request, isr_branch}, 32'h5);
    // Software picks the RC clock before a conversion in sleep.
    sleep_mode <= 1'b1;
    convert(3'h3, 1'b1, 10'h12c, RC_HALF);
    repeat (2) @(posedge hclk);
    check({29'h0, irq_request, wake_request, isr_branch}, 32'h7);
    // The flag stays until software clears it.
    repeat (40) @(posedge hclk);
    rd_chk(OFF_FLAG, 32'h1);
    wr(OFF_FLAG, 8'h00);
    repeat (2) @(posedge hclk);
    check({29'h0, irq_request, wake_request, isr_branch}, 32'h0);
    // A divided clock in sleep gives no completion and keeps the old result.
    wr(OFF_CTRL1, 8'h80);
    wr(OFF_CTRL0, 8'h03);
    repeat (60) @(posedge hclk);
    rd_chk(OFF_FLAG, 32'h0);
    rd_chk(OFF_RES_LOW, 32'h2c);
    sleep_mode <= 1'b0;
    // A software stop after two decisions loads the partial code, filled from the last bit.
    level <= 10'h3a5;
    wr(OFF_CTRL1, 8'he0);
    wr(OFF_CTRL0, 8'h03);
    repeat (240) @(posedge hclk);
    wr(OFF_CTRL0, 8'h01);
    @(posedge hclk);
    check({31'h0, busy}, 32'h0);
    rd_chk(OFF_FLAG, 32'h0);
    rd_chk(OFF_RES_HIGH, 32'h3);
    rd_chk(OFF_RES_LOW, 32'hff);
    tally_and_finish;
  end
endmodule // tb_top
